// [demand_link_consts.svh]
`ifndef DEMAND_LINK_CONSTS_SVH
`define DEMAND_LINK_CONSTS_SVH

// apb register byte offsets
`define DLS_CTRL_OFF 12'h000
`define DLS_TIMEOUT_OFF 12'h004
`define DLS_DIFF_OFF 12'h008
`define DLS_TRKTIME_OFF 12'h00c
`define DLS_STATUS_OFF 12'h010
`define DLS_CLEAR_OFF 12'h014
// ctrl fields
`define DLS_CTRL_EN_BIT 0
`define DLS_CTRL_MODE_LSB 1
`define DLS_CTRL_MODE_MSB 2
// status fields
`define DLS_ST_P1_BIT 0
`define DLS_ST_P2_BIT 1
`define DLS_ST_TOTAL_BIT 2
`define DLS_ST_TRACK_BIT 3
`define DLS_ST_AHI_BIT 4
`define DLS_ST_ALO_BIT 5
// reset values
`define DLS_CTRL_RST 32'h0000_0000
`define DLS_TIMEOUT_MS_RST 16'd40
`define DLS_DIFF_RST 16'h0100
`define DLS_TRKTIME_MS_RST 16'd100
// timing: one millisecond tick at 125 mhz
`define DLS_CLK_MHZ 125
`define DLS_TICK_US 1000
`define DLS_TICK_CYC (`DLS_CLK_MHZ * `DLS_TICK_US)

`endif

// [demand_link_pkg.sv]
package demand_link_pkg;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_DUAL = 2'h1,
    MODE_BACKUP = 2'h2
  } demand_mode_t;

  typedef struct packed {
    logic fast_data;
    logic sync;
    logic [15:0] demand;
  } port_evt_t;

  typedef struct packed {
    logic p1_loss;
    logic p2_loss;
    logic total_loss;
    logic track_alarm;
  } loss_flags_t;

endpackage

// [demand_link_supervisor.sv]
// What this block does
// - dual mode: port-two loss flag set when its fast/sync messages exceed timeout.
// - dual mode: total loss when port one and port two both lost.
// - backup mode: total loss when port one and analog backup lost.
// - total loss always comes with port-one loss set, and with port-two loss in dual mode.
// - backup mode: tracking alarm when difference persists beyond time.
// - dual mode: tracking compares port one against port two demand.
`timescale 1ns/1ps
`default_nettype none
`include "demand_link_consts.svh"

// tick length in clocks is a parameter so that a bench can shorten the ms
module demand_link_supervisor #(
  parameter int TICK_CYC = `DLS_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire demand_link_pkg::port_evt_t port1_evt,
  input wire demand_link_pkg::port_evt_t port2_evt,
  input wire logic [15:0] analog_demand,
  input wire logic analog_high,
  input wire logic analog_low,
  output demand_link_pkg::loss_flags_t flags
);

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_r;
  logic [15:0] timeout_ms_r;
  logic [15:0] diff_r;
  logic [15:0] trk_ms_r;
  logic [16:0] tick_cnt_r;
  logic tick_r;
  logic [15:0] p1_ms_r;
  logic [15:0] p2_ms_r;
  logic [15:0] trk_cnt_r;
  logic p1_loss_r;
  logic p2_loss_r;
  logic total_r;
  logic track_r;
  logic enable;
  demand_link_pkg::demand_mode_t mode;
  logic [15:0] other_demand;
  logic diff_big;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic clr_track;

  assign enable = ctrl_r[`DLS_CTRL_EN_BIT];
  assign mode = demand_link_pkg::demand_mode_t'(
    ctrl_r[`DLS_CTRL_MODE_MSB:`DLS_CTRL_MODE_LSB]);
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  function automatic logic [15:0] absdiff(input logic [15:0] a,
                                          input logic [15:0] b);
    absdiff = (a > b) ? (a - b) : (b - a);
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  always_comb begin
    unique case (paddr)
      `DLS_CTRL_OFF, `DLS_TIMEOUT_OFF, `DLS_DIFF_OFF, `DLS_TRKTIME_OFF,
      `DLS_STATUS_OFF, `DLS_CLEAR_OFF: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // apb: zero wait states, writes and reads complete in the access cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r <= `DLS_CTRL_RST;
      timeout_ms_r <= `DLS_TIMEOUT_MS_RST;
      diff_r <= `DLS_DIFF_RST;
      trk_ms_r <= `DLS_TRKTIME_MS_RST;
    end else if (wr_acc) begin
      unique case (paddr)
        `DLS_CTRL_OFF: ctrl_r <= {29'h0000000, pwdata[2:0]};
        `DLS_TIMEOUT_OFF: timeout_ms_r <= pwdata[15:0];
        `DLS_DIFF_OFF: diff_r <= pwdata[15:0];
        `DLS_TRKTIME_OFF: trk_ms_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  assign clr_track = wr_acc && (paddr == `DLS_CLEAR_OFF) &&
                     pwdata[`DLS_ST_TRACK_BIT];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `DLS_CTRL_OFF: prdata <= ctrl_r;
          `DLS_TIMEOUT_OFF: prdata <= {16'h0000, timeout_ms_r};
          `DLS_DIFF_OFF: prdata <= {16'h0000, diff_r};
          `DLS_TRKTIME_OFF: prdata <= {16'h0000, trk_ms_r};
          `DLS_STATUS_OFF: prdata <= {26'h0000000, analog_low, analog_high,
                                      track_r, total_r, p2_loss_r,
                                      p1_loss_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // millisecond tick shared by all timers
  always_ff @(posedge ref_clk) begin
    if (sys_rst || tick_r) begin
      tick_cnt_r <= 17'h00000;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h00001;
      tick_r <= (tick_cnt_r == 17'(TICK_CYC - 2));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timer restart
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !enable || port1_evt.fast_data || port1_evt.sync)
      p1_ms_r <= 16'h0000;
    else if (tick_r)
      p1_ms_r <= sat_inc(p1_ms_r);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !enable || port2_evt.fast_data || port2_evt.sync)
      p2_ms_r <= 16'h0000;
    else if (tick_r)
      p2_ms_r <= sat_inc(p2_ms_r);
  end

  // loss flags follow the link: a fresh message clears them again
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      p1_loss_r <= 1'b0;
      p2_loss_r <= 1'b0;
    end else begin
      p1_loss_r <= enable && (p1_ms_r > timeout_ms_r);
      p2_loss_r <= enable && (mode == demand_link_pkg::MODE_DUAL) &&
                   (p2_ms_r > timeout_ms_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // total loss is derived from the same timer compares as the loss flags, so holds
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      total_r <= 1'b0;
    else begin
      unique case (mode)
        demand_link_pkg::MODE_DUAL:
          total_r <= enable && (p1_ms_r > timeout_ms_r) &&
                     (p2_ms_r > timeout_ms_r);
        demand_link_pkg::MODE_BACKUP:
          total_r <= enable && (p1_ms_r > timeout_ms_r) &&
                     (analog_high || analog_low);
        default: total_r <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dual compare source
  assign other_demand = (mode == demand_link_pkg::MODE_DUAL) ?
                        port2_evt.demand : analog_demand;
  assign diff_big = absdiff(port1_evt.demand, other_demand) > diff_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !diff_big || !enable ||
        mode == demand_link_pkg::MODE_SINGLE)
      trk_cnt_r <= 16'h0000;
    else if (tick_r)
      trk_cnt_r <= sat_inc(trk_cnt_r);
  end

  // alarm is latched until software clears it; a new trip wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      track_r <= 1'b0;
    else if (trk_cnt_r > trk_ms_r)
      track_r <= 1'b1;
    else if (clr_track)
      track_r <= 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      flags <= '0;
    else
      flags <= '{p1_loss: p1_loss_r, p2_loss: p2_loss_r,
                 total_loss: total_r, track_alarm: track_r};
  end

endmodule // demand_link_supervisor
`default_nettype wire

// [demand_link_supervisor_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module dls_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire demand_link_pkg::port_evt_t port1_evt,
  input wire logic analog_high,
  input wire logic analog_low,
  input wire demand_link_pkg::loss_flags_t flags
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic msg = port1_evt.fast_data | port1_evt.sync;
  // total flag may lag the analog fault by up to two cycles
  wire logic af = analog_high | analog_low;
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("stray ready");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("stray error");
  a_total_p1: assert property (
    flags.total_loss |-> flags.p1_loss) else $error("total no p1");
  a_total_pair: assert property (
    flags.total_loss |-> flags.p2_loss || af || $past(af) || $past(af, 2))
    else $error("total no pair");
  a_quiet_loss: assert property (
    $rose(flags.p1_loss) |-> !$past(msg) && !$past(msg, 2))
    else $error("early loss");
  a_loss_clears: assert property (
    $rose(msg) && flags.p1_loss |-> ##[1:3] !flags.p1_loss)
    else $error("loss kept");
  a_track_latch: assert property (
    flags.track_alarm && !(psel && penable) && !$past(psel && penable)
    |=> flags.track_alarm)
    else $error("track dropped");
  a_reset_zero: assert property (disable iff (1'b0)
    sys_rst |=> flags == 4'h0) else $error("reset flags");
  c_p2: cover property ($rose(flags.p2_loss));
  c_total: cover property ($rose(flags.total_loss));
  c_track: cover property ($rose(flags.track_alarm));
endmodule // dls_checker
bind demand_link_supervisor dls_checker dls_checker_i (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .port1_evt(port1_evt), .analog_high(analog_high),
  .analog_low(analog_low), .flags(flags));
`default_nettype wire

// [demand_link_supervisor_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module demand_link_supervisor_tb;
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic en1 = 1, en2 = 1, ahi = 0, alo = 0, pready, pslverr, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [15:0] dem1 = 16'h1000, dem2 = 16'h1000, adem = 16'h1000;
  demand_link_pkg::port_evt_t p1, p2;
  demand_link_pkg::loss_flags_t flags;
  int n_errors = 0, check_count = 0, cyc = 0;
  demand_link_supervisor #(.TICK_CYC(100)) demand_link_supervisor_i (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port1_evt(p1), .port2_evt(p2),
    .analog_demand(adem), .analog_high(ahi), .analog_low(alo),
    .flags(flags));
  // message period of 80 clocks stays under one shortened ms
  plant_control_model #(.PERIOD(80)) plant_control_model_i (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst), .en1(en1), .en2(en2), .dem1(dem1), .dem2(dem2),
    .port1_evt(p1), .port2_evt(p2));
  always #4 ref_clk = ~ref_clk;
  task automatic results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ms tick shortened to 100 clocks, so the run takes a few thousand cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    if (n == 16) n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic fl(input logic [3:0] x, input int c);
    repeat (c) @(posedge ref_clk);
    chk({28'h0, flags}, {28'h0, x});
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(0, 12'h004, 0);
    chk(q, 32'h28);
    apb(0, 12'h018, 0);
    chk({31'h0, e}, 32'h1);
    apb(1, 12'h004, 32'h1);
    apb(1, 12'h00c, 32'h0);
    apb(1, 12'h008, 32'h10);
    apb(1, 12'h000, 32'h3);
    en2 <= 1'b0;
    dem2 <= 16'h2000;
    fl(4'h5, 1000);
    apb(0, 12'h010, 0);
    chk(q, 32'ha);
    dem2 <= 16'h1000;
    apb(1, 12'h014, 32'h8);
    fl(4'h4, 2);
    $display("test port two loss done");
    en1 <= 1'b0;
    fl(4'he, 1000);
    $display("test dual total done");
    apb(1, 12'h000, 32'h5);
    alo <= 1'b1;
    adem <= 16'h0000;
    fl(4'hb, 1000);
    alo <= 1'b0;
    fl(4'h9, 10);
    en1 <= 1'b1;
    fl(4'h1, 200);
    $display("test backup done");
    results();
  end
endmodule // demand_link_supervisor_tb
`default_nettype wire

// [plant_control_model.sv]
`timescale 1ns/1ps
`default_nettype none
module plant_control_model #(parameter int PERIOD = 20000) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic en1,
  input wire logic en2,
  input wire logic [15:0] dem1,
  input wire logic [15:0] dem2,
  output wire demand_link_pkg::port_evt_t port1_evt,
  output wire demand_link_pkg::port_evt_t port2_evt
);
  int cnt_r;
  always_ff @(posedge ref_clk) begin
    cnt_r <= (sys_rst || cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
  end
  assign port1_evt = {en1 && cnt_r == 1, en1 && cnt_r == 3, dem1};
  assign port2_evt = {en2 && cnt_r == 2, en2 && cnt_r == 4, dem2};
endmodule // plant_control_model
`default_nettype wire
